// *** rtl/icd_pkg.sv ***
package icd_pkg;
	localparam int NCH = 8;
	localparam logic [7:0] OFS_CTRL  = 8'h00;
	localparam logic [7:0] OFS_BITIN = 8'h04;
	localparam logic [7:0] OFS_XEN   = 8'h08;
	localparam logic [7:0] OFS_EXP   = 8'h0C;
	localparam logic [7:0] OFS_IEN   = 8'h10;
	localparam logic [7:0] OFS_DTYPE = 8'h14;
	localparam logic [7:0] OFS_TIME  = 8'h18;
	localparam logic [2:0] DESC_PAGE = 3'h2;
	localparam int CTRL_FIXED = 0;
	localparam int DESC_IRQ   = 0;
	localparam int DESC_RD    = 1;
	localparam int ADDR_LO    = 2;
	localparam int ADDR_HI    = 15;
	localparam int PAGE_HI    = 9;
	localparam int TOP_BIT    = 31;
	localparam logic [7:0]  BITIN_RST = 8'hFF;
	localparam logic [3:0]  SEL_MP    = 4'h8;
	localparam logic [1:0]  DT_ONE    = 2'h0;
	localparam logic [1:0]  DT_FOUR   = 2'h1;
	localparam logic [1:0]  DT_CELL   = 2'h2;
	localparam logic [1:0]  HT_NONSEQ = 2'h2;
	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

	function automatic logic [2:0] txn_beats(input logic [1:0] dt);
		txn_beats = (dt == DT_CELL) ? 3'h1 : (dt == DT_FOUR) ? 3'h5 : 3'h2;
	endfunction

	function automatic logic [7:0] txn_len(input logic [1:0] dt, input logic [3:0] t);
		txn_len = 8'(txn_beats(dt)) * (8'(t) + 8'h01);
	endfunction
endpackage

// *** rtl/icd_arbiter.sv ***
`timescale 1ns/100ps
module icd_arbiter
	import icd_pkg::*;
(
	input  wire logic           hclk,
	input  wire logic           hresetn,
	input  wire logic [NCH-1:0] pend,
	input  wire logic           fixed,
	input  wire logic           restart,
	input  wire logic           skip,
	output logic [3:0]          sel_q
);
	logic [3:0] ptr_q;
	logic [3:0] cand;
	logic       moved_q;

	// lowest index wins
	// Lowest pending index at or above the revolving pointer, else main processor
	// Fixed mode ignores the pointer, even in the cycle it is switched on
	always_comb begin
		cand = SEL_MP;
		for (int i = NCH - 1; i >= 0; i--) begin
			if (pend[i] && (fixed || 4'(i) >= ptr_q)) begin
				cand = 4'(i);
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ptr_q   <= 4'h0;
			moved_q <= 1'b0;
		end else if (restart || fixed) begin
			ptr_q   <= 4'h0;
			moved_q <= 1'b0;
		end else if (skip && !moved_q) begin
			ptr_q   <= (sel_q == SEL_MP) ? 4'h0 : sel_q + 4'h1;
			moved_q <= 1'b1;
		end else begin
			moved_q <= 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sel_q <= SEL_MP;
		end else begin
			sel_q <= cand;
		end
	end

	idle_sel_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(pend == '0) |=> (sel_q == SEL_MP)) else $error("idle arbiter picked a channel");
	fixed_top_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(fixed && pend[0]) |=> (sel_q == 4'h0)) else $error("channel zero lost in fixed mode");
endmodule // icd_arbiter

// *** rtl/icd_bus_seq.sv ***
`timescale 1ns/100ps
module icd_bus_seq
	import icd_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        start,
	input  wire logic        rd,
	input  wire logic [1:0]  dtype,
	input  wire logic [3:0]  tbeat,
	input  wire logic [31:0] addr,
	input  wire logic [31:0] ad_in,
	output logic             busy,
	output logic             done,
	output logic [31:0]      bus_addr_q,
	output logic             bus_rd_q,
	output logic             mem_we_q,
	output logic [31:0]      ad_out_q,
	output logic             ad_oe_q
);
	typedef enum logic {SQ_IDLE, SQ_RUN} icd_seq_t;
	icd_seq_t    st_q, st_d;
	logic [3:0]  cnt_q, cnt_d, t_q, t_d;
	logic [2:0]  b_q, b_d, nb_q, nb_d;
	logic        rd_q, rd_d, dev_q, dev_d, run_d, cell_d;
	logic [1:0]  dt_q, dt_d;
	logic [31:0] a_q, a_d, buf_q, buf_d;
	logic [7:0]  byte_d;

	assign busy = (st_q == SQ_RUN);
	assign done = busy && cnt_q == 4'h0 && b_q == nb_q;

	always_comb begin
		st_d  = st_q;
		b_d   = b_q;
		cnt_d = cnt_q;
		buf_d = buf_q;
		rd_d  = start ? rd : rd_q;
		dt_d  = start ? dtype : dt_q;
		t_d   = start ? tbeat : t_q;
		a_d   = start ? addr : a_q;
		nb_d  = start ? txn_beats(dtype) - 3'h1 : nb_q;
		if (busy && cnt_q == 4'h0) begin
			// Byte devices assemble or split a cell through the holding buffer
			if (dt_q != DT_CELL && rd_q && dev_q) begin
				buf_d = {buf_q[23:0], ad_in[7:0]};
			end else if (dt_q != DT_CELL && !rd_q && !dev_q) begin
				buf_d = ad_in;
			end else if (dt_q == DT_FOUR && dev_q) begin
				buf_d = {buf_q[23:0], 8'h00};
			end
			if (b_q == nb_q) begin
				st_d = SQ_IDLE;
			end else begin
				b_d   = b_q + 3'h1;
				cnt_d = t_q;
			end
		end else if (busy) begin
			cnt_d = cnt_q - 4'h1;
		end
		if (start) begin
			st_d  = SQ_RUN;
			b_d   = 3'h0;
			cnt_d = tbeat;
		end
		run_d  = (st_d == SQ_RUN);
		cell_d = (dt_d == DT_CELL);
		dev_d  = cell_d || (rd_d ? b_d != nb_d : b_d != 3'h0);
		byte_d = (dt_d == DT_FOUR) ? buf_d[31:24] : buf_d[7:0];
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_q  <= SQ_IDLE;
			cnt_q <= 4'h0;
			b_q   <= 3'h0;
			nb_q  <= 3'h0;
			t_q   <= 4'h0;
			rd_q  <= 1'b0;
			dt_q  <= DT_ONE;
			a_q   <= WORD_ZERO;
			buf_q <= WORD_ZERO;
			dev_q <= 1'b0;
		end else begin
			st_q  <= st_d;
			cnt_q <= cnt_d;
			b_q   <= b_d;
			nb_q  <= nb_d;
			t_q   <= t_d;
			rd_q  <= rd_d;
			dt_q  <= dt_d;
			a_q   <= a_d;
			buf_q <= buf_d;
			dev_q <= dev_d;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bus_addr_q <= WORD_ZERO;
			bus_rd_q   <= 1'b0;
			mem_we_q   <= 1'b0;
			ad_out_q   <= WORD_ZERO;
			ad_oe_q    <= 1'b0;
		end else begin
			bus_addr_q <= run_d ? {dev_d, a_d[TOP_BIT-1:0]} : WORD_ZERO;
			bus_rd_q   <= run_d && rd_d;
			mem_we_q   <= run_d && rd_d && (!dev_d || cell_d);
			ad_out_q   <= rd_d ? buf_d : {24'h00_0000, byte_d};
			ad_oe_q    <= run_d && !cell_d && (rd_d ? !dev_d : dev_d);
		end
	end
endmodule // icd_bus_seq

// *** rtl/icd_channel_engine.sv ***
// Decided for this implementation: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/100ps
// How it works
// - coprocessor transfer starts from descriptor once bus is idle
// - descriptor bit one picks read or write
// - instruction wrap with enable raises interrupt
// - both starts share one bus sequencer
// - eight channels, channel zero highest
// - enabled line requests, interrupt enable ignored
// - held or written zero requests transfer
// - disabled channel ignores zero, stays sticky
// - expiry clears enable at page end
// - prioritisation takes one clock
// - grant only when slot fits transaction
// - coprocessor seize wins, channels beat processor
// - fixed mode blocks on a misfit
// - revolving mode tries next lower requester
// - delay instruction restarts arbitration from top
// - per-channel width, timing, low byte lane
// - top address bit selects device
// - increment address, detect page end
// - page end interrupts channel if enabled
module icd_channel_engine
	import icd_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic [31:0]      hrdata,
	output logic             hresp,
	input  wire logic [7:0]  in_n,
	input  wire logic        cop_xfer,
	input  wire logic [3:0]  cop_xfer_reg,
	input  wire logic        cop_delay_exec,
	input  wire logic        cop_seize,
	input  wire logic [15:0] cop_slot,
	input  wire logic        mp_req,
	input  wire logic [7:0]  mp_len,
	output logic             mp_gnt,
	output logic [7:0]       irq_req,
	output logic [31:0]      bus_addr,
	output logic             bus_rd,
	output logic             mem_we,
	input  wire logic [31:0] ad_in,
	output logic [31:0]      ad_out,
	output logic             ad_oe
);
	logic [NCH-1:0]   bitin_q, xen_q, exp_q, ien_q, irq_q, pend, ev;
	logic [NCH-1:0]   bitin_d;
	logic [2*NCH-1:0] dtype_q;
	logic [4*NCH-1:0] time_q;
	logic             fixed_q;
	logic [31:0]      desc_q [NCH];
	logic             wr_q, rd_q, ready_q, resp_q;
	logic [7:0]       ra_q;
	logic [31:0]      rdata_q, rdat;
	logic             xf_q, inst_q;
	logic [2:0]       xf_ch_q, cur_q, sel_ch, st_ch;
	logic [7:0]       mp_cnt_q, sel_len;
	logic             mp_gnt_q;
	logic [3:0]       sel_q;
	logic             bus_idle, sel_is_ch, sel_fit, mp_fit;
	logic             go_inst, go_ch, go_mp, skip, start;
	logic             seq_busy, seq_done, page_end, wrap;
	logic [13:0]      inc;
	logic             desc_hit, wr_desc;

	assign hreadyout = ready_q;
	assign hrdata    = rdata_q;
	assign hresp     = resp_q;
	assign mp_gnt    = mp_gnt_q;
	assign irq_req   = irq_q;

	assign pend = ~bitin_q & xen_q;

	assign sel_ch    = sel_q[2:0];
	assign sel_is_ch = (sel_q != SEL_MP) && pend[sel_ch];
	assign sel_len   = txn_len(dtype_q[2*sel_ch +: 2], time_q[4*sel_ch +: 4]);
	assign sel_fit   = {8'h00, sel_len} <= cop_slot;
	assign mp_fit    = {8'h00, mp_len} <= cop_slot;
	// A new owner waits for the sequencer so the increment lands first
	assign bus_idle  = !seq_busy && mp_cnt_q == 8'h00;
	assign go_inst   = bus_idle && xf_q;
	assign go_ch     = bus_idle && !xf_q && !cop_seize && sel_is_ch && sel_fit;
	assign go_mp     = bus_idle && !xf_q && !cop_seize && !sel_is_ch
		&& sel_q == SEL_MP && mp_req && mp_fit;
	assign skip      = bus_idle && !xf_q && !cop_seize && sel_is_ch && !sel_fit;
	assign start     = go_inst || go_ch;
	assign st_ch     = go_inst ? xf_ch_q : sel_ch;

	assign inc      = desc_q[cur_q][ADDR_HI:ADDR_LO] + 14'h0001;
	assign page_end = inc[PAGE_HI-ADDR_LO:0] == '0;
	assign wrap     = inc == '0;

	assign desc_hit = ra_q[7:5] == DESC_PAGE;
	assign wr_desc  = wr_q && desc_hit;

	icd_arbiter u_arb (
		.hclk    (hclk),
		.hresetn (hresetn),
		.pend    (pend),
		.fixed   (fixed_q),
		.restart (cop_delay_exec),
		.skip    (skip),
		.sel_q   (sel_q)
	);

	icd_bus_seq u_seq (
		.hclk       (hclk),
		.hresetn    (hresetn),
		.start      (start),
		.rd         (desc_q[st_ch][DESC_RD]),
		.dtype      (dtype_q[2*st_ch +: 2]),
		.tbeat      (time_q[4*st_ch +: 4]),
		.addr       (desc_q[st_ch]),
		.ad_in      (ad_in),
		.busy       (seq_busy),
		.done       (seq_done),
		.bus_addr_q (bus_addr),
		.bus_rd_q   (bus_rd),
		.mem_we_q   (mem_we),
		.ad_out_q   (ad_out),
		.ad_oe_q    (ad_oe)
	);

	// Bus slave: writes take effect in the data phase, reads add one wait
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q    <= 1'b0;
			rd_q    <= 1'b0;
			ra_q    <= 8'h00;
			ready_q <= 1'b1;
			rdata_q <= WORD_ZERO;
			resp_q  <= 1'b0;
		end else if (rd_q) begin
			rdata_q <= rdat;
			ready_q <= 1'b1;
			rd_q    <= 1'b0;
			wr_q    <= 1'b0;
		end else if (hready && hsel && htrans == HT_NONSEQ) begin
			ra_q    <= haddr[7:0];
			wr_q    <= hwrite;
			rd_q    <= !hwrite;
			ready_q <= hwrite;
		end else begin
			wr_q <= 1'b0;
		end
	end

	always_comb begin
		rdat = WORD_ZERO;
		if (desc_hit) begin
			rdat = desc_q[ra_q[4:2]];
		end else begin
			case (ra_q)
				OFS_CTRL:  rdat[CTRL_FIXED] = fixed_q;
				OFS_BITIN: rdat[NCH-1:0] = bitin_q;
				OFS_XEN:   rdat[NCH-1:0] = xen_q;
				OFS_EXP:   rdat[NCH-1:0] = exp_q;
				OFS_IEN:   rdat[NCH-1:0] = ien_q;
				OFS_DTYPE: rdat[2*NCH-1:0] = dtype_q;
				OFS_TIME:  rdat = time_q;
				default:   rdat = WORD_ZERO;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fixed_q <= 1'b0;
			exp_q   <= '0;
			ien_q   <= '0;
			dtype_q <= '0;
			time_q  <= '0;
		end else if (wr_q) begin
			if (ra_q == OFS_CTRL) fixed_q <= hwdata[CTRL_FIXED];
			if (ra_q == OFS_EXP) exp_q <= hwdata[NCH-1:0];
			if (ra_q == OFS_IEN) ien_q <= hwdata[NCH-1:0];
			if (ra_q == OFS_DTYPE) dtype_q <= hwdata[2*NCH-1:0];
			if (ra_q == OFS_TIME) time_q <= hwdata;
		end
	end

	// zero requests, pin wins
	// A low pin beats both consume and a software one, so no request is lost
	always_comb begin
		bitin_d = bitin_q;
		if (go_ch) begin
			bitin_d[sel_ch] = 1'b1;
		end
		if (wr_q && ra_q == OFS_BITIN) begin
			bitin_d = hwdata[NCH-1:0];
		end
		bitin_d = bitin_d & in_n;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bitin_q <= BITIN_RST;
		end else begin
			bitin_q <= bitin_d;
		end
	end

	bitin_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(wr_q && ra_q == OFS_BITIN) |=> bitin_q == ($past(hwdata[NCH-1:0]) & $past(in_n)))
		else $error("bit input write not applied");
	bitin_consume_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(go_ch && !(wr_q && ra_q == OFS_BITIN)) |=> bitin_q[$past(sel_ch)] == $past(in_n[sel_ch]))
		else $error("granted request not consumed");

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			xen_q <= '0;
		end else if (wr_q && ra_q == OFS_XEN) begin
			xen_q <= hwdata[NCH-1:0];
		end else if (seq_done && !inst_q && page_end && exp_q[cur_q]) begin
			xen_q[cur_q] <= 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < NCH; i++) desc_q[i] <= WORD_ZERO;
		end else begin
			if (seq_done) desc_q[cur_q][ADDR_HI:ADDR_LO] <= inc;
			if (wr_desc) desc_q[ra_q[4:2]] <= hwdata;
		end
	end

	// A new instruction in the launch cycle is kept, not lost
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			xf_q    <= 1'b0;
			xf_ch_q <= 3'h0;
		end else if (cop_xfer && cop_xfer_reg[3]) begin
			xf_q    <= 1'b1;
			xf_ch_q <= cop_xfer_reg[2:0];
		end else if (go_inst) begin
			xf_q <= 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cur_q  <= 3'h0;
			inst_q <= 1'b0;
		end else if (start) begin
			cur_q  <= st_ch;
			inst_q <= go_inst;
		end
	end

	// Processor holds the bus for its own stated length
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mp_cnt_q <= 8'h00;
			mp_gnt_q <= 1'b0;
		end else if (go_mp) begin
			mp_cnt_q <= mp_len;
			mp_gnt_q <= mp_len != 8'h00;
		end else if (mp_cnt_q != 8'h00) begin
			mp_cnt_q <= mp_cnt_q - 8'h01;
			mp_gnt_q <= mp_cnt_q != 8'h01;
		end
	end

	always_comb begin
		ev = '0;
		if (seq_done && inst_q && wrap && desc_q[cur_q][DESC_IRQ]) ev[cur_q] = 1'b1;
		if (seq_done && !inst_q && page_end && desc_q[cur_q][DESC_IRQ]) ev[cur_q] = 1'b1;
	end

	// interrupt enable ignored when transfer enabled
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_q <= '0;
		end else begin
			irq_q <= ev | (~bitin_q & ien_q & ~xen_q);
		end
	end

	zero_sticky_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(in_n != 8'hFF) |=> ((bitin_q & ~$past(in_n)) == '0))
		else $error("low bit input not caught");
	seize_block_a: assert property (@(posedge hclk) disable iff (!hresetn)
		cop_seize |-> !go_ch && !go_mp) else $error("grant during coprocessor seize");
	slot_fit_a: assert property (@(posedge hclk) disable iff (!hresetn)
		go_ch |-> {8'h00, sel_len} <= cop_slot) else $error("channel granted too small slot");
	enabled_only_a: assert property (@(posedge hclk) disable iff (!hresetn)
		go_ch |-> xen_q[sel_ch] && !bitin_q[sel_ch]) else $error("disabled channel granted");
	xfer_dir_a: assert property (@(posedge hclk) disable iff (!hresetn)
		go_inst |=> bus_rd == $past(desc_q[xf_ch_q][DESC_RD]))
		else $error("instruction transfer direction wrong");
	expiry_clr_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(seq_done && !inst_q && page_end && exp_q[cur_q] && !wr_q)
		|=> !xen_q[$past(cur_q)]) else $error("enable not expired at page end");
	page_irq_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(seq_done && !inst_q && page_end && desc_q[cur_q][DESC_IRQ])
		|=> irq_q[$past(cur_q)]) else $error("page end interrupt missing");
	inst_irq_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(seq_done && inst_q && wrap && desc_q[cur_q][DESC_IRQ])
		|=> irq_q[$past(cur_q)]) else $error("instruction wrap interrupt missing");
	addr_step_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(seq_done && !wr_desc) |=> desc_q[$past(cur_q)][ADDR_HI:ADDR_LO]
		== $past(inc)) else $error("descriptor address not advanced");
	inst_start_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(xf_q && bus_idle) |=> seq_busy && inst_q && cur_q == $past(xf_ch_q))
		else $error("instruction transfer not started");
	chan_dir_a: assert property (@(posedge hclk) disable iff (!hresetn)
		go_ch |=> bus_rd == $past(desc_q[sel_ch][DESC_RD]))
		else $error("channel transfer direction wrong");
	fixed_block_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(fixed_q && sel_is_ch && !sel_fit) |-> !go_mp && !go_ch)
		else $error("bus granted past a blocking misfit");
	mp_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(go_mp && mp_len != 8'h00) |=> mp_gnt) else $error("processor grant missing");
	page_only_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(seq_done && !page_end && !wr_q) |=> xen_q == $past(xen_q))
		else $error("enable dropped away from page end");
	idle_addr_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(!seq_busy && !start) |=> bus_addr == WORD_ZERO) else $error("idle bus not released");
	read_wait_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(hready && hsel && htrans == HT_NONSEQ && !hwrite) |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");
	resp_okay_a: assert property (@(posedge hclk) disable iff (!hresetn)
		!hresp) else $error("error response given");
endmodule // icd_channel_engine

// *** verification/icd_io_partner.sv ***
`timescale 1ns/100ps
module icd_io_partner
	import icd_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic [31:0] bus_addr,
	input  wire logic        bus_rd,
	output logic      [31:0] ad_in
);
	logic [31:0] last_q = 32'h0000_0000;

	// Device answers on its own beat of a read, memory on the memory beat of a write
	// Otherwise the bus floats: show a changing pattern, never a stale copy
	always_comb begin
		if (bus_addr[TOP_BIT] && bus_rd)
			ad_in = {24'h00_0000, bus_addr[9:2] ^ 8'h5A};
		else if (bus_addr !== WORD_ZERO && !bus_addr[TOP_BIT] && !bus_rd)
			ad_in = {bus_addr[15:0], ~bus_addr[15:0]};
		else
			ad_in = ~last_q;
	end

	always @(posedge hclk) begin
		last_q <= ad_in;
	end
endmodule // icd_io_partner

// *** verification/io_channel_dma_controller_tb.sv ***
`timescale 1ns/100ps
module io_channel_dma_controller_tb;
	import icd_pkg::*;
	logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, bus_addr, ad_in, ad_out, rdat, a;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [7:0]  in_n, irq_req, mp_len, irq_seen;
	logic        cop_xfer, cop_delay_exec, cop_seize, mp_req, mp_gnt;
	logic        bus_rd, mem_we, ad_oe, mp_seen, rd_seen, busy_seen;
	logic [3:0]  cop_xfer_reg;
	logic [15:0] cop_slot;
	logic [31:0] desc_m [8];
	int          fails, samples_checked;

	assign hready = hreadyout;

	icd_channel_engine u_icd_channel_engine (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .in_n(in_n),
		.cop_xfer(cop_xfer), .cop_xfer_reg(cop_xfer_reg), .cop_delay_exec(cop_delay_exec),
		.cop_seize(cop_seize), .cop_slot(cop_slot), .mp_req(mp_req), .mp_len(mp_len),
		.mp_gnt(mp_gnt), .irq_req(irq_req), .bus_addr(bus_addr), .bus_rd(bus_rd),
		.mem_we(mem_we), .ad_in(ad_in), .ad_out(ad_out), .ad_oe(ad_oe)
	);

	icd_io_partner u_icd_io_partner (
		.hclk(hclk), .bus_addr(bus_addr), .bus_rd(bus_rd), .ad_in(ad_in)
	);

	initial begin
		hclk = 1'b0;
		forever #50 hclk = ~hclk;
	end

	// Pulses are short (interrupts one cycle, processor grants two), so they are collected here
	always @(negedge hclk) begin
		irq_seen = irq_seen | irq_req;
		mp_seen = mp_seen | mp_gnt;
	end

	function automatic logic [31:0] ra(input logic [7:0] o);
		ra = {24'h00_0000, o};
	endfunction

	function automatic logic [31:0] dsc(input int c);
		dsc = 32'h0000_0040 + 32'(c * 4);
	endfunction

	function automatic logic [31:0] incd(input logic [31:0] v);
		incd = {v[31:16], v[15:2] + 14'h0001, v[1:0]};
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic results;
		$display("checks=%0d fails=%0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// Ready is looked at before the edge that samples it, where it has settled
	task automatic wait_rdy;
		int k;
		k = 0;
		@(negedge hclk);
		while (hreadyout !== 1'b1 && k < 64) begin
			k++;
			@(negedge hclk);
		end
		if (k >= 64) fails++;
		rdat = hrdata;
		@(posedge hclk);
	endtask

	task automatic ahb(input logic w, input logic [31:0] ad, input logic [31:0] wd);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= ad;
		hwrite <= w;
		htrans <= HT_NONSEQ;
		wait_rdy();
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= wd;
		wait_rdy();
	endtask

	task automatic wr(input logic [31:0] ad, input logic [31:0] wd);
		ahb(1'b1, ad, wd);
	endtask

	task automatic rd(input logic [31:0] ad, input logic [31:0] exp);
		ahb(1'b0, ad, WORD_ZERO);
		check(rdat, exp);
		check(hresp, 1'b0);
	endtask

	task automatic wait_bus;
		int k;
		k = 0;
		@(negedge hclk);
		while (bus_addr === WORD_ZERO && k < 200) begin
			k++;
			@(negedge hclk);
		end
		if (k >= 200) fails++;
		a = bus_addr;
		rd_seen = bus_rd;
	endtask

	task automatic wait_idle;
		int k;
		k = 0;
		while (bus_addr !== WORD_ZERO && k < 200) begin
			k++;
			@(negedge hclk);
		end
		repeat (2) @(negedge hclk);
	endtask

	task automatic quiet(input int cyc);
		busy_seen = 1'b0;
		repeat (cyc) begin
			@(negedge hclk);
			if (bus_addr !== WORD_ZERO) busy_seen = 1'b1;
		end
	endtask

	task automatic xfer(input logic [3:0] r);
		@(posedge hclk);
		cop_xfer <= 1'b1;
		cop_xfer_reg <= r;
		@(posedge hclk);
		cop_xfer <= 1'b0;
	endtask

	initial begin
		repeat (20000) @(posedge hclk);
		fails++;
		results();
	end

	initial begin
		hresetn = 1'b0; hsel = 1'b0; haddr = WORD_ZERO; htrans = 2'h0; hwrite = 1'b0;
		hsize = 3'h2; hwdata = WORD_ZERO; in_n = 8'hFF; cop_xfer = 1'b0;
		cop_xfer_reg = 4'h0; cop_delay_exec = 1'b0; cop_seize = 1'b0;
		cop_slot = 16'hFFFF; mp_req = 1'b0; mp_len = 8'h02; irq_seen = 8'h00;
		mp_seen = 1'b0; fails = 0; samples_checked = 0;
		void'($urandom(56));
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		rd(ra(OFS_CTRL), WORD_ZERO);
		rd(ra(OFS_BITIN), ra(BITIN_RST));
		rd(ra(OFS_XEN), WORD_ZERO);
		wr(32'h0000_007C, 32'hFFFF_FFFF);
		rd(32'h0000_007C, WORD_ZERO);
		wr(ra(OFS_DTYPE), 32'h0000_2A6A);
		wr(ra(OFS_TIME), 32'h0003_0000);
		rd(ra(OFS_TIME), 32'h0003_0000);
		for (int c = 0; c < NCH; c++) begin
			desc_m[c] = $urandom & 32'h7FFF_FDF2;
			wr(dsc(c), desc_m[c]);
			rd(dsc(c), desc_m[c]);
		end
		// Two channels forced together by software, lower number first
		wr(ra(OFS_IEN), 32'h0000_0022);
		wr(ra(OFS_XEN), 32'h0000_0022);
		irq_seen = 8'h00;
		wr(ra(OFS_BITIN), 32'h0000_00DD);
		// Channel five follows after a single idle cycle, so catch both grants first
		foreach (desc_m[c]) if (c == 1 || c == 5) begin
			wait_bus();
			check(a, {1'b1, desc_m[c][30:0]});
			check(rd_seen, desc_m[c][DESC_RD]);
			while (bus_addr !== WORD_ZERO) @(negedge hclk);
		end
		wait_idle();
		foreach (desc_m[c]) if (c == 1 || c == 5) begin
			desc_m[c] = incd(desc_m[c]);
			rd(dsc(c), desc_m[c]);
		end
		check(irq_seen, 8'h00);
		rd(ra(OFS_BITIN), 32'h0000_00FF);
		wr(ra(OFS_XEN), WORD_ZERO);
		wr(ra(OFS_IEN), WORD_ZERO);
		// Page end with expiry while the pin stays low
		desc_m[2] = ($urandom & 32'h7FFF_FC00) | 32'h0000_03FF;
		wr(dsc(2), desc_m[2]);
		wr(ra(OFS_EXP), 32'h0000_0004);
		wr(ra(OFS_XEN), 32'h0000_0004);
		irq_seen = 8'h00;
		in_n <= 8'hFB;
		wait_bus();
		check(a, {1'b1, desc_m[2][30:0]});
		wait_idle();
		desc_m[2] = incd(desc_m[2]);
		check(irq_seen, 8'h04);
		quiet(30);
		check(busy_seen, 1'b0);
		rd(ra(OFS_XEN), WORD_ZERO);
		rd(dsc(2), desc_m[2]);
		in_n <= 8'hFF;
		repeat (3) @(posedge hclk);
		rd(ra(OFS_BITIN), 32'h0000_00FB);
		wr(ra(OFS_BITIN), 32'h0000_00FF);
		wr(ra(OFS_EXP), WORD_ZERO);
		// Channel four needs four cycles; the slot gives three
		wr(ra(OFS_CTRL), 32'h0000_0001);
		cop_slot <= 16'h0003;
		wr(ra(OFS_XEN), 32'h0000_0010);
		wr(ra(OFS_BITIN), 32'h0000_00EF);
		repeat (4) @(posedge hclk);
		mp_req <= 1'b1;
		mp_seen = 1'b0;
		quiet(30);
		check(busy_seen, 1'b0);
		check(mp_seen, 1'b0);
		// A higher channel that fits the slot is served despite the block
		wr(ra(OFS_XEN), 32'h0000_0011);
		wr(ra(OFS_BITIN), 32'h0000_00EE);
		wait_bus();
		check(a, {1'b1, desc_m[0][30:0]});
		wait_idle();
		wr(ra(OFS_CTRL), WORD_ZERO);
		mp_seen = 1'b0;
		repeat (20) @(posedge hclk);
		check(mp_seen, 1'b1);
		mp_req <= 1'b0;
		cop_seize <= 1'b1;
		cop_slot <= 16'h0004;
		repeat (8) @(posedge hclk);
		cop_delay_exec <= 1'b1;
		@(posedge hclk);
		cop_delay_exec <= 1'b0;
		quiet(20);
		check(busy_seen, 1'b0);
		@(posedge hclk);
		cop_seize <= 1'b0;
		mp_req <= 1'b1;
		mp_seen = 1'b0;
		wait_bus();
		check(a, {1'b1, desc_m[4][30:0]});
		check(mp_seen, 1'b0);
		@(posedge hclk);
		mp_req <= 1'b0;
		wait_idle();
		desc_m[4] = incd(desc_m[4]);
		wr(ra(OFS_XEN), WORD_ZERO);
		rd(dsc(4), desc_m[4]);
		// Instruction transfer that wraps the whole address field
		desc_m[6] = ($urandom & 32'h7FFF_0000) | 32'h0000_FFFD;
		wr(dsc(6), desc_m[6]);
		irq_seen = 8'h00;
		xfer(4'hE);
		wait_bus();
		check(a, {1'b1, desc_m[6][30:0]});
		check(rd_seen, 1'b0);
		wait_idle();
		desc_m[6] = incd(desc_m[6]);
		check(irq_seen, 8'h40);
		rd(dsc(6), desc_m[6]);
		// One-byte read: device beat, then memory beat on the low lane
		desc_m[7] = ($urandom & 32'h7FFF_FDF0) | 32'h0000_0002;
		wr(dsc(7), desc_m[7]);
		xfer(4'hF);
		wait_bus();
		check(a[TOP_BIT], 1'b1);
		check(rd_seen, 1'b1);
		for (int k = 0; k < 50 && mem_we !== 1'b1; k++) @(negedge hclk);
		check(bus_addr, {1'b0, desc_m[7][30:0]});
		check(ad_out[7:0], desc_m[7][9:2] ^ 8'h5A);
		check(ad_oe, 1'b1);
		wait_idle();
		desc_m[7] = incd(desc_m[7]);
		rd(dsc(7), desc_m[7]);
		// Four-byte write: memory beat, then four bytes most significant first
		desc_m[3] = ($urandom & 32'h7FFF_FDF0) | 32'h0000_0004;
		wr(dsc(3), desc_m[3]);
		xfer(4'hB);
		wait_bus();
		check(a, {1'b0, desc_m[3][30:0]});
		for (int k = 0; k < 4; k++) begin
			@(negedge hclk);
			check(ad_out[7:0], 8'({desc_m[3][15:0], ~desc_m[3][15:0]} >> (24 - 8 * k)));
			check(bus_addr[TOP_BIT], 1'b1);
		end
		wait_idle();
		desc_m[3] = incd(desc_m[3]);
		rd(dsc(3), desc_m[3]);
		results();
	end
endmodule // io_channel_dma_controller_tb
